/* pkg/pia_pkg.sv */
/*
 pia_pkg: constants, enumerations and carriers of the private interrupt assignment block.
 assumes one 20 MHz system clock and a fixed population of processing elements.
*/
package pia_pkg;
	// ----------------------------------------------------------------
	// sizing and feature switches
	// ----------------------------------------------------------------
	localparam int unsigned NUM_PE       = 4;
	localparam int unsigned PE_W         = 2;
	localparam int unsigned PPI_LINES    = 32;
	localparam int unsigned SGI_NUM      = 8;
	localparam int unsigned MSI_DEVS     = 8;
	localparam int unsigned INTX_N       = 4;
	localparam int unsigned WIRED_N      = 5;
	localparam int unsigned LPI_W        = 16;
	localparam int unsigned ADDR_W       = 32;
	localparam bit          HAS_PCIE     = 1'b1;
	localparam bit          HAS_PROFILE  = 1'b1;
	localparam bit          HAS_HYP_VIRT = 1'b1;
	localparam bit          HAS_SEC_HYP  = 1'b1;
	// ----------------------------------------------------------------
	// interrupt ids, security reset value, message ids
	// ----------------------------------------------------------------
	localparam logic [4:0]  ID_SEC_HYP_VIRT = 5'h13;
	localparam logic [4:0]  ID_SEC_HYP_PHYS = 5'h14;
	localparam logic [4:0]  ID_PROF         = 5'h15;
	localparam logic [4:0]  ID_DBG_COMM     = 5'h16;
	localparam logic [4:0]  ID_PMU          = 5'h17;
	localparam logic [4:0]  ID_CROSS_TRIG   = 5'h18;
	localparam logic [4:0]  ID_MAINT        = 5'h19;
	localparam logic [4:0]  ID_HYP_PHYS     = 5'h1A;
	localparam logic [4:0]  ID_VIRT         = 5'h1B;
	localparam logic [4:0]  ID_HYP_VIRT     = 5'h1C;
	localparam logic [4:0]  ID_SEC_PHYS     = 5'h1D;
	localparam logic [4:0]  ID_NS_PHYS      = 5'h1E;
	localparam logic [31:0] SGI_NS_MASK     = 32'h0000_00FF;
	localparam logic [31:0] GRP_SEC_RESET   = 32'h2018_0000;
	localparam logic [15:0] ERR_LPI_ID      = 16'h2000;
	// ----------------------------------------------------------------
	// populated address map and response bound
	// ----------------------------------------------------------------
	localparam logic [31:0] MEM_BASE        = 32'h8000_0000;
	localparam logic [31:0] MEM_SIZE        = 32'h4000_0000;
	localparam logic [31:0] DEV_BASE        = 32'h1000_0000;
	localparam logic [31:0] DEV_SIZE        = 32'h0100_0000;
	localparam int unsigned CLK_NS          = 50;
	localparam int unsigned RSP_LIMIT_NS    = 1000;
	localparam int unsigned RSP_LIMIT_CYC   = (RSP_LIMIT_NS / CLK_NS) < 1 ? 1 : (RSP_LIMIT_NS / CLK_NS);
	// ----------------------------------------------------------------
	// enumerations and carriers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {RPT_ABORT = 2'h0, RPT_SERR = 2'h1, RPT_WIRED = 2'h2, RPT_MSG = 2'h3} pia_rpt_t;
	typedef enum logic [1:0] {XS_IDLE = 2'b00, XS_LOOK = 2'b01, XS_ISSUE = 2'b11} pia_xst_t;
	typedef struct packed {
		logic ns_phys_tmr; logic virt_tmr; logic cross_trig; logic pmu_ovf;
		logic dbg_comm; logic prof_buf; logic hyp_virt_tmr; logic hyp_phys_tmr;
		logic maint; logic sec_phys_tmr; logic sec_hyp_phys_tmr; logic sec_hyp_virt_tmr;
	} pia_src_t;
	typedef struct packed {logic [2:0] id; logic [NUM_PE-1:0] targets;} pia_sgi_t;
	typedef struct packed {logic [2:0] dev; logic [LPI_W-1:0] evt;} pia_msi_t;
	typedef struct packed {logic valid; logic [PE_W-1:0] pe; logic [LPI_W-1:0] base;} pia_xent_t;
	typedef struct packed {logic [PE_W-1:0] pe; logic [LPI_W-1:0] id;} pia_lpi_t;
	typedef struct packed {logic [ADDR_W-1:0] addr; logic wr; logic [31:0] wdata;} pia_acc_t;
	typedef struct packed {logic err; logic [31:0] rdata;} pia_rsp_t;
endpackage

/* rtl/pia_ppi_map.sv */
/*
 pia_ppi_map: places one processing element's private sources on their fixed ids.
 assumes sources are levels synchronous to clk; one instance per processing element.
*/
`timescale 1ns/1ps
module pia_ppi_map (
	input  wire logic                            clk,
	input  wire logic                            rst_b,
	input  pia_pkg::pia_src_t                    src,
	output logic [pia_pkg::PPI_LINES-1:0]        ppi_q
);
	import pia_pkg::*;

	// ----------------------------------------------------------------
	// id placement, identical for every element
	// ----------------------------------------------------------------
	// unused ids read low; optional sources are held low when absent
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ppi_q <= '0;
		end else begin
			ppi_q                  <= '0;
			ppi_q[ID_NS_PHYS]      <= src.ns_phys_tmr;
			ppi_q[ID_VIRT]         <= src.virt_tmr;
			ppi_q[ID_CROSS_TRIG]   <= src.cross_trig;
			ppi_q[ID_PMU]          <= src.pmu_ovf;
			ppi_q[ID_DBG_COMM]     <= src.dbg_comm;
			ppi_q[ID_PROF]         <= HAS_PROFILE & src.prof_buf;
			ppi_q[ID_HYP_VIRT]     <= HAS_HYP_VIRT & src.hyp_virt_tmr;
			ppi_q[ID_HYP_PHYS]     <= src.hyp_phys_tmr;
			ppi_q[ID_MAINT]        <= src.maint;
			ppi_q[ID_SEC_PHYS]     <= src.sec_phys_tmr;
			ppi_q[ID_SEC_HYP_PHYS] <= HAS_SEC_HYP & src.sec_hyp_phys_tmr;
			ppi_q[ID_SEC_HYP_VIRT] <= HAS_SEC_HYP & src.sec_hyp_virt_tmr;
		end
	end
endmodule

/* rtl/pia_bus_guard.sv */
/*
 pia_bus_guard: terminates accesses to unpopulated space and bounds every response.
 assumes one outstanding access; downstream answers with a one-cycle valid.
*/
`timescale 1ns/1ps
module pia_bus_guard (
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire logic                 req_valid,
	output logic                      req_ready,
	input  pia_pkg::pia_acc_t         req,
	output logic                      rsp_valid_q,
	output pia_pkg::pia_rsp_t         rsp_q,
	output logic                      dn_valid_q,
	input  wire logic                 dn_ready,
	output pia_pkg::pia_acc_t         dn_req_q,
	input  wire logic                 dn_rsp_valid,
	input  pia_pkg::pia_rsp_t         dn_rsp,
	output logic                      err_evt_q
);
	import pia_pkg::*;

	logic       busy_q;
	logic [4:0] cnt_q;

	// address decode against the populated regions
	function automatic logic in_map(input logic [ADDR_W-1:0] a);
		in_map = ((a - MEM_BASE) < MEM_SIZE) || ((a - DEV_BASE) < DEV_SIZE);
	endfunction

	assign req_ready = !busy_q;

	// ----------------------------------------------------------------
	// termination: unmapped at once, mapped within the bound
	// ----------------------------------------------------------------
	// a late downstream answer after the bound is dropped while idle, but forwarded if a new access is then in flight
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			busy_q      <= 1'b0;
			cnt_q       <= '0;
			rsp_valid_q <= 1'b0;
			rsp_q       <= '0;
			dn_valid_q  <= 1'b0;
			dn_req_q    <= '0;
			err_evt_q   <= 1'b0;
		end else begin
			rsp_valid_q <= 1'b0;
			err_evt_q   <= 1'b0;
			if (!busy_q && req_valid) begin
				if (in_map(req.addr)) begin
					busy_q     <= 1'b1;
					cnt_q      <= '0;
					dn_valid_q <= 1'b1;
					dn_req_q   <= req;
				end else begin
					rsp_valid_q <= 1'b1;
					rsp_q       <= '{err: 1'b1, rdata: '0};
					err_evt_q   <= 1'b1;
				end
			end else if (busy_q) begin
				if (dn_valid_q && dn_ready) begin
					dn_valid_q <= 1'b0;
				end
				cnt_q <= cnt_q + 5'h01;
				if (dn_rsp_valid) begin
					busy_q      <= 1'b0;
					rsp_valid_q <= 1'b1;
					rsp_q       <= dn_rsp;
				end else if (cnt_q == 5'(RSP_LIMIT_CYC - 1)) begin
					busy_q      <= 1'b0;
					dn_valid_q  <= 1'b0;
					rsp_valid_q <= 1'b1;
					rsp_q       <= '{err: 1'b1, rdata: '0};
					err_evt_q   <= 1'b1;
				end
			end
		end
	end
endmodule

/* rtl/pia_top.sv */
/*
 pia_top: private interrupt assignment, message translation, legacy wired path and
 termination of accesses to unpopulated address space.
 assumes all inputs synchronous to clk; the interrupt controller consumes the id-indexed
 lines per element, the message output and the wired levels.
*/
`timescale 1ns/1ps
module pia_top (
	input  wire logic                                          clk,
	input  wire logic                                          rst_b,
	// private sources, one group per element
	input  pia_pkg::pia_src_t [pia_pkg::NUM_PE-1:0]            pe_src,
	// software generated requests and their acknowledges
	input  wire logic                                          sgi_valid,
	input  pia_pkg::pia_sgi_t                                  sgi_req,
	input  wire logic [pia_pkg::NUM_PE-1:0][pia_pkg::SGI_NUM-1:0] sgi_ack,
	// id-indexed lines per element and security group per id
	output logic [pia_pkg::NUM_PE-1:0][pia_pkg::PPI_LINES-1:0] pe_irq,
	output logic [pia_pkg::PPI_LINES-1:0]                      id_secure,
	input  wire logic                                          grp_we,
	input  wire logic                                          grp_nonsecure,
	input  wire logic [pia_pkg::PPI_LINES-1:0]                 grp_val,
	// translation table load
	input  wire logic                                          xlt_we,
	input  wire logic [2:0]                                    xlt_idx,
	input  pia_pkg::pia_xent_t                                 xlt_ent,
	// msi writes in, message interrupts out
	input  wire logic                                          msi_valid,
	output logic                                               msi_ready,
	input  pia_pkg::pia_msi_t                                  msi,
	output logic                                               lpi_valid,
	input  wire logic                                          lpi_ready,
	output pia_pkg::pia_lpi_t                                  message_based_interrupt,
	output logic                                               xlt_miss,
	// legacy levels and shared wired outputs
	input  wire logic [pia_pkg::INTX_N-1:0]                    intx_lvl,
	output logic [pia_pkg::WIRED_N-1:0]                        wired_irq,
	// requester side of the memory path
	input  wire logic                                          acc_valid,
	output logic                                               acc_ready,
	input  pia_pkg::pia_acc_t                                  acc,
	output logic                                               rsp_valid,
	output pia_pkg::pia_rsp_t                                  rsp,
	// populated target side of the memory path
	output logic                                               dn_valid,
	input  wire logic                                          dn_ready,
	output pia_pkg::pia_acc_t                                  dn_req,
	input  wire logic                                          dn_rsp_valid,
	input  pia_pkg::pia_rsp_t                                  dn_rsp,
	// error reporting choice and clear
	input  pia_pkg::pia_rpt_t                                  rpt_mode,
	output logic                                               serr_irq,
	input  wire logic                                          err_clr
);
	import pia_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [NUM_PE-1:0][PPI_LINES-1:0] ppi_w;
	logic [NUM_PE-1:0][SGI_NUM-1:0]   sgi_pend_q;
	logic [PPI_LINES-1:0]             grp_sec_q;
	pia_xent_t                        xlt_tab_q [MSI_DEVS];
	pia_xst_t                         xst_q;
	pia_msi_t                         msi_q;
	pia_lpi_t                         lpi_q;
	logic                             xlt_miss_q;
	logic                             err_msg_q;
	logic                             serr_q;
	logic                             err_wired_q;
	logic [INTX_N-1:0]                intx_q;
	logic                             g_rsp_valid;
	pia_rsp_t                         g_rsp;
	logic                             g_err;
	pia_rpt_t                         rpt_q;
	logic                             rsp_valid_q;
	pia_rsp_t                         rsp_q;

	// ----------------------------------------------------------------
	// private source placement
	// ----------------------------------------------------------------
	// one mapper per element keeps each element's sources on its own lines
	for (genvar p = 0; p < NUM_PE; p++) begin : g_pe
		pia_ppi_map u_map (
			.clk   (clk),
			.rst_b (rst_b),
			.src   (pe_src[p]),
			.ppi_q (ppi_w[p])
		);
	end

	// ----------------------------------------------------------------
	// software generated ids
	// ----------------------------------------------------------------
	// sticky pending per element and id; a new request beats a same-cycle ack
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sgi_pend_q <= '0;
		end else begin
			for (int p = 0; p < NUM_PE; p++) begin
				for (int k = 0; k < SGI_NUM; k++) begin
					if (sgi_valid && sgi_req.targets[p] && (sgi_req.id == 3'(k))) begin
						sgi_pend_q[p][k] <= 1'b1;
					end else if (sgi_ack[p][k]) begin
						sgi_pend_q[p][k] <= 1'b0;
					end
				end
			end
		end
	end

	// ids 0..7 software, 8..15 unused, 16..31 private sources
	always_comb begin
		for (int p = 0; p < NUM_PE; p++) begin
			pe_irq[p]                  = ppi_w[p] & ~32'h0000_FFFF;
			pe_irq[p][SGI_NUM-1:0]     = sgi_pend_q[p];
		end
	end

	// ----------------------------------------------------------------
	// security group per id
	// ----------------------------------------------------------------
	// only a secure write may regroup; software ids stay non-secure always
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			grp_sec_q <= GRP_SEC_RESET;
		end else if (grp_we && !grp_nonsecure) begin
			grp_sec_q <= grp_val & ~SGI_NS_MASK;
		end
	end

	assign id_secure = grp_sec_q;

	// ----------------------------------------------------------------
	// translation table
	// ----------------------------------------------------------------
	// small table, one entry per requesting device, loaded by firmware
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			for (int i = 0; i < MSI_DEVS; i++) begin
				xlt_tab_q[i] <= '0;
			end
		end else if (xlt_we) begin
			xlt_tab_q[xlt_idx] <= xlt_ent;
		end
	end

	// ----------------------------------------------------------------
	// message translation state machine
	// ----------------------------------------------------------------
	// a pending error message goes first so it cannot starve behind msi traffic
	assign msi_ready = (xst_q == XS_IDLE) && !err_msg_q && HAS_PCIE;
	assign lpi_valid = (xst_q == XS_ISSUE);
	assign message_based_interrupt       = lpi_q;
	assign xlt_miss  = xlt_miss_q;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			xst_q      <= XS_IDLE;
			msi_q      <= '0;
			lpi_q      <= '0;
			xlt_miss_q <= 1'b0;
		end else begin
			xlt_miss_q <= 1'b0;
			unique case (xst_q)
				XS_IDLE: begin
					if (err_msg_q) begin
						lpi_q <= '{pe: '0, id: ERR_LPI_ID};
						xst_q <= XS_ISSUE;
					end else if (msi_valid && msi_ready) begin
						msi_q <= msi;
						xst_q <= XS_LOOK;
					end
				end
				XS_LOOK: begin
					if (xlt_tab_q[msi_q.dev].valid) begin
						lpi_q.pe <= xlt_tab_q[msi_q.dev].pe;
						lpi_q.id <= LPI_W'(xlt_tab_q[msi_q.dev].base + msi_q.evt);
						xst_q    <= XS_ISSUE;
					end else begin
						xlt_miss_q <= 1'b1;                                // unmapped device, dropped
						xst_q      <= XS_IDLE;
					end
				end
				XS_ISSUE: begin
					if (lpi_ready) begin
						xst_q <= XS_IDLE;
					end
				end
				default: begin
					xst_q <= XS_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// legacy wired path
	// ----------------------------------------------------------------
	// levels pass through one flop, never turned into edges
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			intx_q <= '0;
		end else begin
			intx_q <= intx_lvl;
		end
	end

	assign wired_irq = {err_wired_q, intx_q};
	assign serr_irq  = serr_q;

	// ----------------------------------------------------------------
	// access termination and bounded response
	// ----------------------------------------------------------------
	pia_bus_guard u_guard (
		.clk          (clk),
		.rst_b        (rst_b),
		.req_valid    (acc_valid),
		.req_ready    (acc_ready),
		.req          (acc),
		.rsp_valid_q  (g_rsp_valid),
		.rsp_q        (g_rsp),
		.dn_valid_q   (dn_valid),
		.dn_ready     (dn_ready),
		.dn_req_q     (dn_req),
		.dn_rsp_valid (dn_rsp_valid),
		.dn_rsp       (dn_rsp),
		.err_evt_q    (g_err)
	);

	// report mode is sampled with the access so a mid-flight change cannot split it
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rpt_q <= RPT_ABORT;
		end else if (acc_valid && acc_ready) begin
			rpt_q <= rpt_mode;
		end
	end

	// error flag reaches the requester only as a precise abort
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rsp_valid_q <= 1'b0;
			rsp_q       <= '0;
		end else begin
			rsp_valid_q <= g_rsp_valid;
			rsp_q.rdata <= g_rsp.rdata;
			rsp_q.err   <= g_rsp.err & (rpt_q == RPT_ABORT);
		end
	end

	assign rsp_valid = rsp_valid_q;
	assign rsp       = rsp_q;

	// sticky reporting flags; a fresh error beats a same-cycle clear
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			serr_q      <= 1'b0;
			err_wired_q <= 1'b0;
			err_msg_q   <= 1'b0;
		end else begin
			if (g_err && (rpt_q == RPT_SERR)) begin
				serr_q <= 1'b1;
			end else if (err_clr) begin
				serr_q <= 1'b0;
			end
			if (g_err && (rpt_q == RPT_WIRED)) begin
				err_wired_q <= 1'b1;
			end else if (err_clr) begin
				err_wired_q <= 1'b0;
			end
			if (g_err && (rpt_q == RPT_MSG)) begin
				err_msg_q <= 1'b1;
			end else if ((xst_q == XS_IDLE) && err_msg_q) begin
				err_msg_q <= 1'b0;
			end
		end
	end
endmodule

/* tb/pia_asserts.sv */
/*
 pia_asserts: port checks for the private interrupt block.
 assumes it is bound onto pia_top and shares its single clock and reset.
*/
`timescale 1ns/1ps
module pia_asserts (
	input  wire logic                                           clk,
	input  wire logic                                           rst_b,
	input  pia_pkg::pia_src_t [pia_pkg::NUM_PE-1:0]             pe_src,
	input  wire logic [pia_pkg::NUM_PE-1:0][pia_pkg::PPI_LINES-1:0] pe_irq,
	input  wire logic [pia_pkg::PPI_LINES-1:0]                  id_secure,
	input  wire logic [pia_pkg::INTX_N-1:0]                     intx_lvl,
	input  wire logic [pia_pkg::WIRED_N-1:0]                    wired_irq,
	input  wire logic                                           acc_valid,
	input  wire logic                                           acc_ready,
	input  pia_pkg::pia_acc_t                                   acc,
	input  wire logic                                           rsp_valid,
	input  pia_pkg::pia_rsp_t                                   rsp,
	input  pia_pkg::pia_rpt_t                                   rpt_mode
);
	import pia_pkg::*;
	// ----------------------------------------------------------------
	// one clock domain, reset disables every check
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// source placement: one flop, no gating, per element
	a_ns_phys_id: assert property ($past(rst_b) |-> pe_irq[0][30] == $past(pe_src[0].ns_phys_tmr))
		else $error("ns physical timer not on id 30");
	a_virt_id: assert property ($past(rst_b) |-> pe_irq[1][27] == $past(pe_src[1].virt_tmr))
		else $error("virtual timer not on id 27");
	a_pmu_direct: assert property ($past(rst_b) |-> pe_irq[3][23] == $past(pe_src[3].pmu_ovf))
		else $error("monitor overflow not on id 23");
	a_sec_hyp_virt: assert property ($past(rst_b) |-> pe_irq[2][19] == $past(pe_src[2].sec_hyp_virt_tmr))
		else $error("secure hyp virtual timer not on id 19");
	a_gap_zero: assert property (pe_irq[1][15:8] == 8'h00)
		else $error("ids 8 to 15 driven");
	a_sgi_nonsec: assert property (id_secure[7:0] == 8'h00)
		else $error("software id marked secure");
	a_legacy_lvl: assert property ($past(rst_b) |-> wired_irq[3:0] == $past(intx_lvl))
		else $error("legacy level not passed");
	// bound covers the 20-cycle downstream timeout plus pipeline
	a_rsp_bound: assert property (acc_valid && acc_ready |-> ##[1:24] rsp_valid)
		else $error("access not answered in time");
	a_unmap_abort: assert property (acc_valid && acc_ready && acc.addr[31:28] == 4'h0 && rpt_mode == RPT_ABORT
		|-> ##2 rsp_valid && rsp.err) else $error("unpopulated access not aborted");
endmodule
bind pia_top pia_asserts u_chk (.clk, .rst_b, .pe_src, .pe_irq, .id_secure, .intx_lvl, .wired_irq,
	.acc_valid, .acc_ready, .acc, .rsp_valid, .rsp, .rpt_mode);

/* tb/pia_mem_model.sv */
/*
 pia_mem_model: populated target behind the access guard.
 assumes one request at a time; latency chosen by the bench, long ones force a timeout.
*/
`timescale 1ns/1ps
module pia_mem_model (
	input  wire logic        clk,
	input  wire logic        dn_valid,
	input  pia_pkg::pia_acc_t dn_req,
	input  wire logic [5:0]  lat,
	output logic             dn_ready,
	output logic             dn_rsp_valid,
	output pia_pkg::pia_rsp_t dn_rsp
);
	import pia_pkg::*;
	logic        busy_q;
	logic [5:0]  cnt_q;
	logic [31:0] addr_q;
	assign dn_ready = !busy_q;
	// data toggles every cycle except the answer cycle so a stale answer is never mistaken for a real one
	always @(posedge clk) begin
		dn_rsp_valid <= 1'b0;
		dn_rsp <= ~dn_rsp;
		if (!busy_q && dn_valid) begin
			busy_q <= 1'b1;
			cnt_q <= lat;
			addr_q <= dn_req.addr;
		end else if (busy_q && cnt_q == 6'h00) begin
			busy_q <= 1'b0;
			dn_rsp_valid <= 1'b1;
			dn_rsp <= {1'b0, addr_q ^ 32'h5A5A_5A5A};
		end else if (busy_q)
			cnt_q <= cnt_q - 6'h01;
	end
	initial begin
		busy_q = 1'b0;
		dn_rsp = '0;
	end
endmodule

/* tb/tb_pia_top.sv */
/*
 tb_pia_top: self-checking bench for pia_top with a memory model on the target side.
 assumes inputs change at the falling edge; seeded xorshift gives repeatable stimulus.
*/
`timescale 1ns/1ps
module tb_pia_top;
	import pia_pkg::*;
	logic                             clk, rst_b, sgi_valid, grp_we, grp_nonsecure, xlt_we, msi_valid;
	logic                             msi_ready, lpi_valid, lpi_ready, xlt_miss, acc_valid, acc_ready;
	logic                             rsp_valid, dn_valid, dn_ready, dn_rsp_valid, serr_irq, err_clr;
	pia_src_t [NUM_PE-1:0]            pe_src;
	pia_sgi_t                         sgi_req;
	logic [NUM_PE-1:0][SGI_NUM-1:0]   sgi_ack;
	logic [NUM_PE-1:0][PPI_LINES-1:0] pe_irq;
	logic [31:0]                      id_secure, grp_val, seed;
	logic [2:0]                       xlt_idx;
	pia_xent_t                        xlt_ent;
	pia_msi_t                         msi;
	pia_lpi_t                         message_based_interrupt;
	logic [3:0]                       intx_lvl;
	logic [4:0]                       wired_irq;
	pia_acc_t                         acc, dn_req;
	pia_rsp_t                         rsp, dn_rsp;
	pia_rpt_t                         rpt_mode;
	logic [5:0]                       lat;
	logic [15:0]                      base [8];
	int                               n_mismatch, checks_done, i, p, k;
	// source field k (from the top) lands on this id
	localparam int ID_OF [12] = '{30, 27, 24, 23, 22, 21, 28, 26, 25, 29, 20, 19};

	pia_top DUT (.clk, .rst_b, .pe_src, .sgi_valid, .sgi_req, .sgi_ack, .pe_irq, .id_secure, .grp_we,
		.grp_nonsecure, .grp_val, .xlt_we, .xlt_idx, .xlt_ent, .msi_valid, .msi_ready, .msi, .lpi_valid,
		.lpi_ready, .message_based_interrupt, .xlt_miss, .intx_lvl, .wired_irq, .acc_valid, .acc_ready, .acc, .rsp_valid, .rsp,
		.dn_valid, .dn_ready, .dn_req, .dn_rsp_valid, .dn_rsp, .rpt_mode, .serr_irq, .err_clr);
	pia_mem_model u_mem (.clk, .dn_valid, .dn_req, .lat, .dn_ready, .dn_rsp_valid, .dn_rsp);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] exp_ppi(input logic [11:0] s);
		exp_ppi = '0;
		for (int j = 0; j < 12; j++) exp_ppi[ID_OF[j]] = s[11-j];
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// one access, raised for one cycle once ready, then wait for the answer pulse
	task automatic access(input logic [31:0] a, input pia_rpt_t m);
		for (k = 0; k < 40 && !acc_ready; k++) @(negedge clk);
		rpt_mode = m;
		acc = {a, 1'b0, xs()};
		acc_valid = 1'b1;
		@(negedge clk);
		acc_valid = 1'b0;
		for (k = 0; k < 40 && !rsp_valid; k++) @(negedge clk);
		chk("rsp valid", 32'h1, 32'(rsp_valid));
	endtask
	task automatic take_lpi();
		lpi_ready = 1'b1;
		@(negedge clk);
		lpi_ready = 1'b0;
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// watchdog: the sequence needs about 210 cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		end_of_test();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst_b, sgi_valid, grp_we, grp_nonsecure, xlt_we, msi_valid, lpi_ready, acc_valid, err_clr} = '0;
		{pe_src, sgi_req, sgi_ack, grp_val, xlt_idx, xlt_ent, msi, intx_lvl, acc, lat} = '0;
		rpt_mode = RPT_ABORT;
		seed = 32'd52953;
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		chk("grp reset", GRP_SEC_RESET, id_secure);
		// one-hot walk over source fields, rotating elements, then random sources; legacy levels random throughout
		for (i = 0; i < 40; i++) begin
			for (p = 0; p < NUM_PE; p++) pe_src[p] = (i < 12) ? ((p == i % 4) ? 12'h800 >> i : 12'h000) : 12'(xs());
			intx_lvl = 4'(xs());
			@(negedge clk);
			for (p = 0; p < NUM_PE; p++) chk("ppi", exp_ppi(pe_src[p]), pe_irq[p]);
			chk("intx", {28'h0, intx_lvl}, {28'h0, wired_irq[3:0]});
		end
		pe_src = '0;
		@(negedge clk);
		// every software id, random targets, acknowledged before the next
		for (i = 0; i < SGI_NUM; i++) begin
			sgi_req = '{id: 3'(i), targets: 4'(xs()) | 4'h1};
			sgi_valid = 1'b1;
			@(negedge clk);
			sgi_valid = 1'b0;
			for (p = 0; p < NUM_PE; p++) chk("sgi", 32'(sgi_req.targets[p]) << i, pe_irq[p]);
			sgi_ack = '1;
			@(negedge clk);
			sgi_ack = '0;
		end
		// non-secure group write ignored, secure one lands with software ids kept non-secure
		grp_val = xs();
		grp_we = 1'b1;
		grp_nonsecure = 1'b1;
		@(negedge clk);
		grp_nonsecure = 1'b0;
		chk("grp ns", GRP_SEC_RESET, id_secure);
		@(negedge clk);
		grp_we = 1'b0;
		chk("grp s", grp_val & 32'hFFFF_FF00, id_secure);
		// translation table, device 5 left unloaded
		xlt_we = 1'b1;
		for (i = 0; i < 8; i++) begin
			base[i] = 16'(xs());
			xlt_idx = 3'(i);
			xlt_ent = '{valid: i != 5, pe: 2'(i), base: base[i]};
			@(negedge clk);
		end
		xlt_we = 1'b0;
		for (i = 0; i < 8; i++) begin
			for (k = 0; k < 5 && !msi_ready; k++) @(negedge clk);
			msi = '{dev: 3'(i), evt: 16'(xs())};
			msi_valid = 1'b1;
			@(negedge clk);
			msi_valid = 1'b0;
			for (k = 0; k < 5 && !lpi_valid && !xlt_miss; k++) @(negedge clk);
			if (i == 5) chk("miss", 32'h1, 32'(xlt_miss));
			else chk("lpi", {13'h0, 1'b1, 2'(i), 16'(base[i] + msi.evt)}, {13'h0, lpi_valid, message_based_interrupt});
			take_lpi();
		end
		// unpopulated access under every reporting choice
		for (i = 0; i < 4; i++) begin
			access(xs() & 32'h0FFF_FFFC, pia_rpt_t'(i));
			chk("rsp err", 32'(i == 0), 32'(rsp.err));
			if (i == 1) chk("serr", 32'h1, 32'(serr_irq));
			if (i == 2) chk("wired err", 32'h1, 32'(wired_irq[4]));
			if (i == 3) begin
				chk("msi ready", 32'h0, 32'(msi_ready));
				for (k = 0; k < 5 && !lpi_valid; k++) @(negedge clk);
				chk("err msg", {13'h0, 1'b1, 2'h0, ERR_LPI_ID}, {13'h0, lpi_valid, message_based_interrupt});
				take_lpi();
			end
			err_clr = 1'b1;
			@(negedge clk);
			err_clr = 1'b0;
			chk("err clr", 32'h0, {30'h0, serr_irq, wired_irq[4]});
		end
		// populated accesses, quick answers then one too slow to wait for
		for (i = 0; i < 4; i++) begin
			lat = 6'(xs() % 8);
			access((i[0] ? 32'h8000_0000 : 32'h1000_0000) | (xs() & 32'h00FF_FFFC), RPT_ABORT);
			chk("rdata", acc.addr ^ 32'h5A5A_5A5A, rsp.rdata);
		end
		lat = 6'd40;
		access(32'h8000_0100, RPT_ABORT);
		chk("timeout err", 32'h1, 32'(rsp.err));
		for (k = 0; k < 45; k++) begin
			@(negedge clk);
			chk("late rsp", 32'h0, 32'(rsp_valid));
		end
		end_of_test();
	end
endmodule
